// [rtl/spmp_pkg.sv]
// shared constants for the serial peripheral port
package spmp_pkg;
	localparam int DATA_BITS = 8;
	localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] IDLE_TX_BYTE = 8'h00;
	localparam logic [2:0] RATE_DIV4 = 3'h0;
	localparam logic [2:0] RATE_DIV64 = 3'h4;
	localparam int HALF_DIV_MIN = 2;
	localparam int HALF_DIV_WIDTH = 7;
	localparam int SYS_CLK_MHZ = 100;
	localparam int SYNC_STAGES = 2;
endpackage

// [rtl/spmp_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spmp_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// pin and synchronised level
	input wire logic pinIn,
	output logic syncOut
);
	logic firstStage;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			firstStage <= RESET_LEVEL;
			syncOut <= RESET_LEVEL;
		end
		else
		begin
			firstStage <= pinIn;
			syncOut <= firstStage;
		end
	end
endmodule

// [rtl/spmp_rate_gen.sv]
// master serial clock half-period tick generator
`timescale 1ns/1ps
module spmp_rate_gen (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// control
	input wire logic run,
	input wire logic [2:0] rateSel,
	// half-period tick
	output logic halfTick
);
	logic [spmp_pkg::HALF_DIV_WIDTH-1:0] count;
	logic [spmp_pkg::HALF_DIV_WIDTH-1:0] halfLen;

	// divisor 4..128 per code, codes above 100 saturate at 128
	function automatic logic [spmp_pkg::HALF_DIV_WIDTH-1:0] half_of(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > spmp_pkg::RATE_DIV64) ? 3'h5 : sel;
		half_of = 7'(spmp_pkg::HALF_DIV_MIN) << s;
	endfunction

	assign halfLen = half_of(rateSel);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !run)
		begin
			count <= '0;
			halfTick <= 1'b0;
		end
		else if (count == halfLen - 7'h1)
		begin
			count <= '0;
			halfTick <= 1'b1;
		end
		else
		begin
			count <= count + 7'h1;
			halfTick <= 1'b0;
		end
	end

	halftick_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(run && !halfTick && $past(halfTick) && $stable(rateSel) && rateSel == spmp_pkg::RATE_DIV4)
		|=> halfTick) else $error("divide by 4 half period wrong");
endmodule

// [rtl/spmp_port.sv]
// serial peripheral port, master or slave, byte exchange engine
`timescale 1ns/1ps
// Overview of operation
// - eight serial clocks exchange one byte
// - unselected slave ignores serial clock
// - unselected slave floats its data output
// - master clock divides system clock 4..128
// - rate code 000 is /4, doubling, else /128
// - controller_select chooses master; master initiates
// - master write when empty starts transfer
// - write while busy sets write collision
// - transfer done flag, interrupt when enabled
// - writes transmit, reads return received byte
// - bit order selectable both directions
// - order bit 0 msb first, 1 lsb
// - overrun keeps old byte, blocks reception
// - overrun no interrupt; done keeps requesting
// - slave counts edges, done after eight
// - late slave load sends zero byte
// - phase 0 samples first edge, select frames
// - phase 1 first edge starts transfer
// - polarity only sets idle clock level
// - polarity 0 idles low, 1 high
// - master select low sets mode fault
// - mode fault clears enable and master
// - select disable suppresses mode fault
// - collision no interrupt; flags software cleared
// - only done and fault raise interrupt
module spmp_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// control settings
	input wire logic lsbFirst,
	input wire logic controllerSelectSet,
	input wire logic controllerSelectClr,
	input wire logic samplePhase,
	input wire logic idleClockLevel,
	input wire logic selectPinDisable,
	input wire logic [2:0] rateDividerSelect,
	input wire logic portEnableSet,
	input wire logic portEnableClr,
	input wire logic interruptEnable,
	// data register access
	input wire logic dataWrite,
	input wire logic [7:0] dataWriteValue,
	input wire logic dataRead,
	output logic [7:0] dataReadValue,
	// flag clears from software
	input wire logic transferDoneClr,
	input wire logic modeFaultClr,
	input wire logic writeCollisionClr,
	input wire logic receiveOverrunClr,
	// status
	output logic portEnable,
	output logic controllerSelect,
	output logic transferDoneFlag,
	output logic modeFaultFlag,
	output logic writeCollisionFlag,
	output logic receiveOverrunFlag,
	output logic interruptReq,
	// serial pins
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic selectIn
);
	typedef enum logic [1:0] {IDLE, LEAD, TRAIL} spmp_state_t;
	spmp_state_t state;
	logic sckSync, selSync, sckPrev, selPrev;
	logic [7:0] txShift, rxShift;
	logic txFull, busy;
	logic [2:0] bitCount;
	logic halfTick;
	logic masterMode, slaveSel, edgeRise, edgeFall, leadEdge, trailEdge;
	logic selFall, doShift, doSample, byteDone, mFault, txDoneSeen;
	logic mosiSync, inBit;
	logic outBit;

	spmp_sync #(.RESET_LEVEL(1'b0)) sckSyncInst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.pinIn(sckIn), .syncOut(sckSync));
	spmp_sync #(.RESET_LEVEL(1'b1)) selSyncInst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.pinIn(selectIn), .syncOut(selSync));
	// slave data follows the synchronised clock
	spmp_sync #(.RESET_LEVEL(1'b0)) mosiSyncInst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.pinIn(mosiIn), .syncOut(mosiSync));
	spmp_rate_gen rateInst (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(masterMode && busy),
		.rateSel(rateDividerSelect), .halfTick(halfTick));

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			sckPrev <= 1'b0;
			selPrev <= 1'b1;
		end
		else
		begin
			sckPrev <= sckSync;
			selPrev <= selSync;
		end
	end

	assign masterMode = portEnable && controllerSelect;
	// select ignored only with phase 1 and select disable
	assign slaveSel = portEnable && !controllerSelect &&
		(!selSync || (samplePhase && selectPinDisable));
	assign edgeRise = sckSync && !sckPrev;
	assign edgeFall = !sckSync && sckPrev;
	// leading edge leaves idle level, which polarity alone defines
	assign leadEdge = idleClockLevel ? edgeFall : edgeRise;
	assign trailEdge = idleClockLevel ? edgeRise : edgeFall;
	assign selFall = !selSync && selPrev;
	assign mFault = masterMode && !selectPinDisable && !selSync;
	assign inBit = masterMode ? misoIn : mosiSync;

	// which phase samples and which shifts
	always_comb
	begin
		doShift = 1'b0;
		doSample = 1'b0;
		if (masterMode)
		begin
			doSample = halfTick && state == (samplePhase ? TRAIL : LEAD);
			doShift = halfTick && samplePhase && state == LEAD && bitCount != 3'h0;
			doShift = doShift || (halfTick && !samplePhase && state == TRAIL);
		end
		else if (slaveSel)
		begin
			doSample = samplePhase ? trailEdge : leadEdge;
			doShift = samplePhase ? (leadEdge && bitCount != 3'h0) : trailEdge;
		end
	end
	assign byteDone = doSample && bitCount == spmp_pkg::BIT_COUNT_LAST;

	// serial clock and transfer state for master
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !portEnable)
		begin
			state <= IDLE;
			busy <= 1'b0;
			sckOut <= 1'b0;
		end
		else if (masterMode)
		begin
			sckOut <= idleClockLevel;
			if (!busy && txFull)
			begin
				busy <= 1'b1;
				state <= LEAD;
			end
			else if (busy && halfTick)
			begin
				if (state == LEAD)
				begin
					state <= TRAIL;
					sckOut <= !idleClockLevel;
				end
				else
				begin
					state <= LEAD;
					if (byteDone || sckTransferEnded())
					begin
						busy <= 1'b0;
						state <= IDLE;
					end
				end
			end
			else if (busy)
			begin
				sckOut <= (state == TRAIL) ? !idleClockLevel : idleClockLevel;
			end
		end
		else
		begin
			state <= IDLE;
			busy <= slaveSel && (bitCount != 3'h0 || busy) && !byteDone;
			sckOut <= idleClockLevel;
		end
	end

	// true once the eighth bit has been sampled
	function automatic logic sckTransferEnded();
		sckTransferEnded = bitCount == 3'h0 && txDoneSeen;
	endfunction
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !busy)
			txDoneSeen <= 1'b0;
		else if (byteDone)
			txDoneSeen <= 1'b1;
	end

	// bit counter
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !portEnable || (!controllerSelect && selSync && !(samplePhase && selectPinDisable)))
			bitCount <= 3'h0;
		else if (!controllerSelect && !samplePhase && selFall)
			bitCount <= 3'h0;
		else if (doSample)
			bitCount <= bitCount + 3'h1;
	end

	// transmit shifter with collision check
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !portEnable)
		begin
			txShift <= spmp_pkg::RESET_BYTE;
			txFull <= 1'b0;
		end
		else if (byteDone)
		begin
			txShift <= spmp_pkg::IDLE_TX_BYTE;
			txFull <= 1'b0;
		end
		else if (dataWrite && !txFull && !(busy || bitCount != 3'h0))
		begin
			txShift <= dataWriteValue;
			txFull <= 1'b1;
		end
		else if (doShift)
			txShift <= lsbFirst ? {1'b0, txShift[7:1]} : {txShift[6:0], 1'b0};
	end
	assign outBit = lsbFirst ? txShift[0] : txShift[7];

	// receive shifter and buffer
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !portEnable)
		begin
			rxShift <= spmp_pkg::RESET_BYTE;
			dataReadValue <= spmp_pkg::RESET_BYTE;
		end
		else if (doSample)
		begin
			rxShift <= lsbFirst ? {inBit, rxShift[7:1]} : {rxShift[6:0], inBit};
			if (byteDone && !transferDoneFlag)
				dataReadValue <= lsbFirst ? {inBit, rxShift[7:1]} : {rxShift[6:0], inBit};
		end
	end

	// pin drive
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mosiOut <= 1'b0;
			mosiOe <= 1'b0;
			misoOut <= 1'b0;
			misoOe <= 1'b0;
			sckOe <= 1'b0;
		end
		else
		begin
			mosiOut <= masterMode ? outBit : 1'b0;
			mosiOe <= masterMode;
			sckOe <= masterMode;
			misoOut <= slaveSel ? outBit : 1'b0;
			misoOe <= slaveSel;
		end
	end

	// mode bits, cleared on fault
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			portEnable <= 1'b0;
			controllerSelect <= 1'b0;
		end
		else if (mFault)
		begin
			portEnable <= 1'b0;
			controllerSelect <= 1'b0;
		end
		else
		begin
			if (portEnableSet)
				portEnable <= 1'b1;
			else if (portEnableClr)
				portEnable <= 1'b0;
			if (controllerSelectSet)
				controllerSelect <= 1'b1;
			else if (controllerSelectClr)
				controllerSelect <= 1'b0;
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			transferDoneFlag <= 1'b0;
			modeFaultFlag <= 1'b0;
			writeCollisionFlag <= 1'b0;
			receiveOverrunFlag <= 1'b0;
		end
		else
		begin
			transferDoneFlag <= byteDone || (transferDoneFlag && !transferDoneClr);
			modeFaultFlag <= mFault || (modeFaultFlag && !modeFaultClr);
			writeCollisionFlag <= (portEnable && dataWrite && (txFull || busy || bitCount != 3'h0))
				|| (writeCollisionFlag && !writeCollisionClr);
			receiveOverrunFlag <= (byteDone && transferDoneFlag)
				|| (receiveOverrunFlag && !receiveOverrunClr);
		end
	end

	// single request from done and fault only
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			interruptReq <= 1'b0;
		else
			interruptReq <= interruptEnable && (transferDoneFlag || (modeFaultFlag && !selectPinDisable));
	end

	done_sets_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		byteDone |=> transferDoneFlag) else $error("done flag not set");
	overrun_keeps_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(byteDone && transferDoneFlag && portEnable) |=> receiveOverrunFlag && $stable(dataReadValue))
		else $error("overrun handling wrong");
	fault_disables_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mFault |=> !portEnable && !controllerSelect && modeFaultFlag) else $error("mode fault effect wrong");
	unselected_float_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!controllerSelect && selSync && !(samplePhase && selectPinDisable)) |=> !misoOe)
		else $error("miso driven while unselected");
	collision_keeps_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(portEnable && dataWrite && txFull && !byteDone && !doShift) |=> writeCollisionFlag && $stable(txShift))
		else $error("collision handling wrong");
	ignore_unselected_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!controllerSelect && selSync && !(samplePhase && selectPinDisable)) |-> !doSample)
		else $error("clock accepted while unselected");
	irq_sources_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!transferDoneFlag && !modeFaultFlag) |=> !interruptReq) else $error("stray interrupt");
	idle_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(masterMode && !busy && $stable(idleClockLevel)) |=> sckOut == $past(idleClockLevel))
		else $error("idle clock level wrong");
	disabled_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!portEnable |=> bitCount == 3'h0 && !sckOe) else $error("disabled port active");
endmodule

// [tb/spmp_partner.sv]
// far-side model: slave answering the port as master, master driving it as slave
`timescale 1ns/1ps
module spmp_partner (
	// clock
	input wire logic sys_clk,
	// transfer format
	input wire logic idleClockLevel,
	input wire logic samplePhase,
	input wire logic lsbFirst,
	// port pins observed
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic mosiOut,
	input wire logic misoOut,
	// pins driven into the port
	output logic sckIn,
	output logic mosiIn,
	output logic misoIn,
	output logic selectIn
);
	logic [7:0] reply = 8'h00;
	logic [7:0] got = 8'h00;
	logic [3:0] outIdx = 4'h0;
	logic lastSck = 1'b0;
	initial
	begin
		sckIn = 1'b0;
		mosiIn = 1'b0;
		misoIn = 1'b1;
		selectIn = 1'b1;
	end
	function automatic logic pick(input logic [7:0] b, input int k);
		return lsbFirst ? b[k] : b[7 - k];
	endfunction
	// slave side: first bit stands before any clock edge
	task automatic arm(input logic [7:0] v);
		reply = v;
		outIdx = samplePhase ? 4'h0 : 4'h1;
		misoIn = pick(v, 0);
		lastSck = idleClockLevel;
	endtask
	always @(posedge sys_clk)
		if (sckOe && sckOut !== lastSck)
		begin
			lastSck <= sckOut;
			if ((sckOut !== idleClockLevel) ^ samplePhase)
				got <= lsbFirst ? {mosiOut, got[7:1]} : {got[6:0], mosiOut};
			else if (outIdx < 4'h8)
			begin
				misoIn <= pick(reply, outIdx);
				outIdx <= outIdx + 4'h1;
			end
			else
				misoIn <= ~misoIn;
		end
	task automatic half();
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic sel(input logic v);
		selectIn <= v;
	endtask
	// clock toggles while not selected
	task automatic noise();
		repeat (16)
		begin
			half();
			sckIn <= ~sckIn;
		end
	endtask
	// master side: select held low for the whole byte, clock idle between frames
	task automatic drive(input logic [7:0] tx, output logic [7:0] rx);
		int k;
		rx = 8'h00;
		sckIn <= idleClockLevel;
		selectIn <= 1'b0;
		for (k = 0; k < 8; k++)
		begin
			if (!samplePhase)
				mosiIn <= pick(tx, k);
			half();
			if (!samplePhase)
				rx = lsbFirst ? {misoOut, rx[7:1]} : {rx[6:0], misoOut};
			sckIn <= ~idleClockLevel;
			if (samplePhase)
				mosiIn <= pick(tx, k);
			half();
			if (samplePhase)
				rx = lsbFirst ? {misoOut, rx[7:1]} : {rx[6:0], misoOut};
			sckIn <= idleClockLevel;
		end
		half();
		selectIn <= 1'b1;
		mosiIn <= ~mosiIn;
	endtask
endmodule

// [tb/test_spmp_port.sv]
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module test_spmp_port;
	logic sys_clk, sys_rst, lsbFirst, samplePhase, idleClockLevel, selectPinDisable, interruptEnable;
	logic controllerSelectSet, controllerSelectClr, portEnableSet, portEnableClr, dataWrite, dataRead;
	logic [2:0] rateDividerSelect;
	logic [7:0] dataWriteValue, dataReadValue, tx, rx, seen;
	logic transferDoneClr, modeFaultClr, writeCollisionClr, receiveOverrunClr;
	logic portEnable, controllerSelect, transferDoneFlag, modeFaultFlag, writeCollisionFlag;
	logic receiveOverrunFlag, interruptReq, sckIn, sckOut, sckOe, mosiIn, mosiOut, mosiOe;
	logic misoIn, misoOut, misoOe, selectIn;
	int nFail = 0;
	int comparisons = 0;
	int n;
	wire [3:0] flags = {receiveOverrunFlag, writeCollisionFlag, modeFaultFlag, transferDoneFlag};
	spmp_port i_spmp_port (.sys_clk, .sys_rst, .lsbFirst, .controllerSelectSet, .controllerSelectClr,
		.samplePhase, .idleClockLevel, .selectPinDisable, .rateDividerSelect, .portEnableSet,
		.portEnableClr, .interruptEnable, .dataWrite, .dataWriteValue, .dataRead, .dataReadValue,
		.transferDoneClr, .modeFaultClr, .writeCollisionClr, .receiveOverrunClr, .portEnable,
		.controllerSelect, .transferDoneFlag, .modeFaultFlag, .writeCollisionFlag, .receiveOverrunFlag,
		.interruptReq, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe,
		.selectIn);
	spmp_partner i_spmp_partner (.sys_clk, .idleClockLevel, .samplePhase, .lsbFirst, .sckOut, .sckOe,
		.mosiOut, .misoOut, .sckIn, .mosiIn, .misoIn, .selectIn);
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp)
		begin
			nFail++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			nFail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (nFail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] v);
		dataWrite <= 1'b1;
		dataWriteValue <= v;
		tick(1);
		dataWrite <= 1'b0;
	endtask
	task automatic clr(input logic [3:0] m);
		{receiveOverrunClr, writeCollisionClr, modeFaultClr, transferDoneClr} <= m;
		tick(1);
		{receiveOverrunClr, writeCollisionClr, modeFaultClr, transferDoneClr} <= 4'h0;
		tick(1);
	endtask
	task automatic mode(input logic m);
		portEnableSet <= 1'b1;
		controllerSelectSet <= m;
		controllerSelectClr <= !m;
		tick(1);
		{portEnableSet, controllerSelectSet, controllerSelectClr} <= 3'h0;
		tick(2);
	endtask
	task automatic cfg(input logic [2:0] c);
		{lsbFirst, samplePhase, idleClockLevel} <= c;
		rateDividerSelect <= c;
		tick(4);
	endtask
	task automatic waitHi(input int f);
		n = 0;
		while (flags[f] !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
		chk1("flag", 1'b1, flags[f]);
		dataRead <= 1'b1;
		tick(1);
		dataRead <= 1'b0;
		tick(1);
	endtask
	initial
	begin
		#600000;
		nFail++;
		tally_and_finish();
	end
	initial
	begin
		{sys_rst, lsbFirst, samplePhase, idleClockLevel, selectPinDisable, interruptEnable} = 6'h20;
		{controllerSelectSet, controllerSelectClr, portEnableSet, portEnableClr, dataWrite, dataRead} = 6'h00;
		{transferDoneClr, modeFaultClr, writeCollisionClr, receiveOverrunClr} = 4'h0;
		rateDividerSelect = 3'h0;
		dataWriteValue = 8'h00;
		tick(20);
		sys_rst <= 1'b0;
		tick(2);
		chk1("enable at reset", 1'b0, portEnable);
		interruptEnable <= 1'b1;
		mode(1'b1);
		chk1("master", 1'b1, controllerSelect);
		for (int i = 0; i < 8; i++)
		begin
			cfg(i[2:0]);
			chk1("sck idle", i[0], sckOut);
			chk1("sck drive", 1'b1, sckOe);
			chk1("mosi drive", 1'b1, mosiOe);
			tx = 8'(8'h1d * (i + 1));
			rx = {tx[0], tx[7:1]} ^ 8'h5a;
			i_spmp_partner.arm(rx);
			wr(tx);
			for (n = 0; sckOut === i[0] && n < 600; n++)
				tick(1);
			for (n = 0; sckOut !== i[0] && n < 600; n++)
				tick(1);
			chk8("half period", 8'(2 << ((i > 5) ? 5 : i)), n[7:0]);
			wr(~tx);
			tick(2);
			chk1("collision", 1'b1, writeCollisionFlag);
			chk1("irq early", 1'b0, interruptReq);
			waitHi(0);
			chk8("sent", tx, i_spmp_partner.got);
			chk8("received", rx, dataReadValue);
			chk1("irq", 1'b1, interruptReq);
			chk1("collision kept", 1'b1, writeCollisionFlag);
			for (n = 0; sckOut !== i[0] && n < 600; n++)
				tick(1);
			clr(4'h5);
		end
		cfg(3'h0);
		i_spmp_partner.arm(8'h6b);
		wr(8'h4e);
		waitHi(0);
		i_spmp_partner.arm(8'hd2);
		wr(8'hb1);
		waitHi(3);
		chk8("kept byte", 8'h6b, dataReadValue);
		chk1("irq on overrun", 1'b1, interruptReq);
		interruptEnable <= 1'b0;
		tick(2);
		chk1("irq masked", 1'b0, interruptReq);
		interruptEnable <= 1'b1;
		clr(4'h9);
		selectPinDisable <= 1'b1;
		i_spmp_partner.sel(1'b0);
		tick(8);
		chk1("fault off", 1'b0, modeFaultFlag);
		selectPinDisable <= 1'b0;
		waitHi(1);
		chk1("enable after fault", 1'b0, portEnable);
		chk1("master after fault", 1'b0, controllerSelect);
		chk1("irq on fault", 1'b1, interruptReq);
		i_spmp_partner.sel(1'b1);
		clr(4'h2);
		mode(1'b0);
		i_spmp_partner.noise();
		chk1("unselected done", 1'b0, transferDoneFlag);
		chk1("unselected miso", 1'b0, misoOe);
		chk1("slave sck drive", 1'b0, sckOe);
		i_spmp_partner.drive(8'hc3, seen);
		waitHi(0);
		chk8("slave received", 8'hc3, dataReadValue);
		chk8("slave idle byte", 8'h00, seen);
		clr(4'h1);
		wr(8'h96);
		i_spmp_partner.drive(8'h3e, seen);
		waitHi(0);
		chk8("slave sent", 8'h96, seen);
		chk8("slave received", 8'h3e, dataReadValue);
		portEnableClr <= 1'b1;
		tick(1);
		portEnableClr <= 1'b0;
		tick(2);
		chk1("disabled", 1'b0, portEnable);
		tally_and_finish();
	end
endmodule
